// ### hdl/ebatc_regs.vh
// constants for the acknowledge-terminated external bus unit
`ifndef EBATC_REGS_VH
`define EBATC_REGS_VH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define EBATC_ADDR_W        24
`define EBATC_DATA_W        16
`define EBATC_BE_W          4
`define EBATC_SEL_W         3
`define EBATC_CS_N          6
`define EBATC_WSC_W         6
`define EBATC_CNT_W         10

// ----------------------------------------------------------------
// configuration encodings
// ----------------------------------------------------------------
`define EBATC_ACK_GROUP     3'h5
`define EBATC_WSC_ACK       6'h3F
`define EBATC_SEL_ACK       1'b0

// ----------------------------------------------------------------
// clock period in picoseconds, timing counts in system clock periods
// ----------------------------------------------------------------
`define EBATC_CLK_PERIOD_PS 8000
`define EBATC_TIMEOUT_CNT   10'h3FE
`define EBATC_MIN_WAIT_CNT  10'h002
`define EBATC_ACK_HOLD_CNT  2'h1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define EBATC_RST_ADDR      24'h00_0000
`define EBATC_RST_DATA      16'h0000
`define EBATC_RST_CNT       10'h000

`endif

// ### hdl/ebatc_sync.v
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps

module ebatc_sync #(
  parameter             WIDTH     = 1,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  // clock and reset
  input  wire             sys_clk,
  input  wire             reset_n,
  // data
  input  wire [WIDTH-1:0] asyncIn,
  output reg  [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stageOne_ff;

  // ----------------------------------------------------------------
  // two stages, first stage read only by the second
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stageOne_ff <= RESET_VAL;
      syncOut     <= RESET_VAL;
    end else begin
      stageOne_ff <= asyncIn;
      syncOut     <= stageOne_ff;
    end
  end

endmodule

// ### hdl/ebatc_core.v
// read cycle engine of the external bus unit with acknowledge termination
`timescale 1ns/1ps
`include "ebatc_regs.vh"

// Functional notes
// RULE1 - bus error after 1022 clocks without acknowledge
// RULE2 - acknowledge honoured only on select five
// RULE3 - acknowledge input is active low
// RULE4 - partner acknowledges within 1019 clocks
// RULE5 - output enable negates 3-4 clocks after acknowledge
// RULE6 - select negates half clock after strobe
// RULE7 - partner data valid one clock after acknowledge
// RULE8 - strobe assertion point set by config bit
// RULE9 - byte enables in reads only if bit clear
// RULE10 - internal wait states end without acknowledge
// RULE11 - address and select start together
// RULE12 - select idle one clock between accesses
// RULE13 - address, select, direction launch on falling edge
// RULE14 - acknowledge mode needs all-ones count, select zero
// RULE15 - synchronise acknowledge, count from select assertion
// RULE16 - time-out ends cycle and reports error
module ebatc_core (
  // clock and reset
  input  wire                       sys_clk,
  input  wire                       reset_n,
  // internal request
  input  wire                       reqValid,
  input  wire [`EBATC_ADDR_W-1:0]   reqAddr,
  input  wire [`EBATC_SEL_W-1:0]    reqSelect,
  input  wire [`EBATC_BE_W-1:0]     reqByteEn,
  output reg                        reqReady,
  // internal answer
  output reg                        rspDone,
  output reg  [`EBATC_DATA_W-1:0]   rspData,
  output reg                        rspBusErr,
  // select five low configuration bits
  input  wire [`EBATC_WSC_W-1:0]    waitStateCount,
  input  wire                       ackWaitSelect,
  input  wire                       readStrobeAssertCtrl,
  input  wire                       byteEnableReadCtrl,
  // external pins
  output reg  [`EBATC_ADDR_W-1:0]   extAddr,
  output reg  [`EBATC_CS_N-1:0]     extSelect_n,
  output reg                        extReadWrite,
  output reg                        extOutEnable_n,
  output reg  [`EBATC_BE_W-1:0]     byteEnable_n,
  input  wire                       dataAck_n,
  input  wire [`EBATC_DATA_W-1:0]   extDataIn
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE   = 3'h0;
  localparam [2:0] ST_DELAY  = 3'h1;
  localparam [2:0] ST_ACCESS = 3'h2;
  localparam [2:0] ST_HOLD   = 3'h3;
  localparam [2:0] ST_GAP    = 3'h4;

  reg  [2:0]                 state_ff;
  reg  [`EBATC_CNT_W-1:0]    cnt_ff;
  reg  [1:0]                 holdCnt_ff;
  reg                        ackMode_ff;
  reg  [`EBATC_WSC_W-1:0]    waitLimit_ff;
  reg  [`EBATC_SEL_W-1:0]    sel_ff;
  reg  [`EBATC_BE_W-1:0]     be_ff;
  reg  [`EBATC_ADDR_W-1:0]   addrInt_ff;
  reg                        csInt_ff;
  wire                       ackSync_n;
  wire [`EBATC_DATA_W-1:0]   dataSync;
  wire                       ackModeReq;
  wire                       waitDone;
  wire                       timedOut;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  ebatc_sync #(
    .WIDTH     (1),
    .RESET_VAL (1'b1)
  ) u_ack_sync (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .asyncIn (dataAck_n),
    .syncOut (ackSync_n)
  ); // RULE15

  ebatc_sync #(
    .WIDTH     (`EBATC_DATA_W),
    .RESET_VAL (`EBATC_RST_DATA)
  ) u_data_sync (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .asyncIn (extDataIn),
    .syncOut (dataSync)
  );

  // ----------------------------------------------------------------
  // cycle termination decisions
  // ----------------------------------------------------------------
  assign ackModeReq = (reqSelect == `EBATC_ACK_GROUP) &&                 // RULE2
                      (waitStateCount == `EBATC_WSC_ACK) &&              // RULE14
                      (ackWaitSelect == `EBATC_SEL_ACK);                 // RULE14
  assign waitDone   = (cnt_ff >= {{(`EBATC_CNT_W-`EBATC_WSC_W){1'b0}}, waitLimit_ff}) &&
                      (cnt_ff >= `EBATC_MIN_WAIT_CNT);                   // RULE10
  assign timedOut   = (cnt_ff >= `EBATC_TIMEOUT_CNT);                    // RULE1

  // ----------------------------------------------------------------
  // rising edge engine
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff       <= ST_IDLE;
      cnt_ff         <= `EBATC_RST_CNT;
      holdCnt_ff     <= 2'h0;
      ackMode_ff     <= 1'b0;
      waitLimit_ff   <= {`EBATC_WSC_W{1'b0}};
      sel_ff         <= {`EBATC_SEL_W{1'b0}};
      be_ff          <= {`EBATC_BE_W{1'b0}};
      addrInt_ff     <= `EBATC_RST_ADDR;
      csInt_ff       <= 1'b0;
      reqReady       <= 1'b0;
      rspDone        <= 1'b0;
      rspData        <= `EBATC_RST_DATA;
      rspBusErr      <= 1'b0;
      extOutEnable_n <= 1'b1;
      byteEnable_n   <= {`EBATC_BE_W{1'b1}};
    end else begin
      rspDone   <= 1'b0;
      rspBusErr <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          reqReady <= 1'b1;
          cnt_ff   <= `EBATC_RST_CNT;
          if (reqValid && reqReady) begin
            reqReady     <= 1'b0;
            addrInt_ff   <= reqAddr;                                     // RULE11
            csInt_ff     <= 1'b1;                                        // RULE11
            sel_ff       <= reqSelect;
            be_ff        <= reqByteEn;
            ackMode_ff   <= ackModeReq;
            waitLimit_ff <= waitStateCount;
            if (readStrobeAssertCtrl) begin
              state_ff <= ST_DELAY;                                      // RULE8
            end else begin
              extOutEnable_n <= 1'b0;                                    // RULE8
              if (!byteEnableReadCtrl) begin
                byteEnable_n <= ~reqByteEn;                              // RULE9
              end
              state_ff <= ST_ACCESS;
            end
          end
        end
        ST_DELAY: begin
          cnt_ff         <= cnt_ff + 1'b1;
          extOutEnable_n <= 1'b0;                                        // RULE8
          if (!byteEnableReadCtrl) begin
            byteEnable_n <= ~be_ff;                                      // RULE9
          end
          state_ff <= ST_ACCESS;
        end
        ST_ACCESS: begin
          cnt_ff <= cnt_ff + 1'b1;                                       // RULE15
          if (ackMode_ff) begin
            if (!ackSync_n) begin                                        // RULE3
              holdCnt_ff <= `EBATC_ACK_HOLD_CNT;
              state_ff   <= ST_HOLD;                                     // RULE5
            end else if (timedOut) begin
              extOutEnable_n <= 1'b1;                                    // RULE16
              byteEnable_n   <= {`EBATC_BE_W{1'b1}};                     // RULE16
              csInt_ff       <= 1'b0;                                    // RULE16
              rspDone        <= 1'b1;
              rspBusErr      <= 1'b1;                                    // RULE1
              state_ff       <= ST_GAP;
            end
          end else if (waitDone) begin
            extOutEnable_n <= 1'b1;                                      // RULE10
            byteEnable_n   <= {`EBATC_BE_W{1'b1}};
            csInt_ff       <= 1'b0;
            rspDone        <= 1'b1;
            rspData        <= dataSync;
            state_ff       <= ST_GAP;
          end
        end
        ST_HOLD: begin
          if (holdCnt_ff == 2'h1) begin
            extOutEnable_n <= 1'b1;                                      // RULE5
            byteEnable_n   <= {`EBATC_BE_W{1'b1}};
            csInt_ff       <= 1'b0;                                      // RULE6
            rspDone        <= 1'b1;
            rspData        <= dataSync;                                  // RULE7
            state_ff       <= ST_GAP;
          end
          holdCnt_ff <= holdCnt_ff - 1'b1;
        end
        ST_GAP: begin
          state_ff <= ST_IDLE;                                           // RULE12
        end
        default: begin
          state_ff       <= ST_IDLE;
          csInt_ff       <= 1'b0;
          extOutEnable_n <= 1'b1;
          byteEnable_n   <= {`EBATC_BE_W{1'b1}};
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // falling edge launch of address, select and direction
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `EBATC_CS_N; gi = gi + 1) begin : g_sel
      localparam [`EBATC_SEL_W-1:0] SEL_IDX = gi;
      always @(negedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          extSelect_n[gi] <= 1'b1;
        end else begin
          extSelect_n[gi] <= ~(csInt_ff && (sel_ff == SEL_IDX));         // RULE13
        end
      end
    end
  endgenerate

  always @(negedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      extAddr      <= `EBATC_RST_ADDR;
      extReadWrite <= 1'b1;
    end else begin
      extAddr      <= addrInt_ff;                                        // RULE13
      extReadWrite <= 1'b1;
    end
  end

endmodule

// ### verification/ebatc_assertions.sv
// port checks for the read engine
`timescale 1ns/1ps
module ebatc_checker (
  // clock and request
  input wire        sys_clk,
  input wire        reset_n,
  input wire        reqValid,
  input wire [23:0] reqAddr,
  input wire [2:0]  reqSelect,
  input wire        reqReady,
  // answer and config
  input wire        rspDone,
  input wire        rspBusErr,
  input wire [5:0]  waitStateCount,
  input wire        ackWaitSelect,
  input wire        readStrobeAssertCtrl,
  input wire        byteEnableReadCtrl,
  // pins
  input wire [23:0] extAddr,
  input wire [5:0]  extSelect_n,
  input wire        extOutEnable_n,
  input wire [3:0]  byteEnable_n,
  input wire        dataAck_n
);
  reg  [10:0] selCnt_ff;
  wire        take    = reqValid && reqReady;
  wire        ackMode = waitStateCount == 6'h3F && !ackWaitSelect;
  always @(posedge sys_clk or negedge reset_n)
    if (!reset_n) selCnt_ff <= 11'h000;
    else selCnt_ff <= extSelect_n[5] ? 11'h000 : selCnt_ff + 11'h001;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_oe_after_ack: assert property ($fell(dataAck_n) && !extSelect_n[5] && ackMode |-> ##[3:4] rspDone && extOutEnable_n)
    else $error("strobe late after ack");
  a_cs_after_oe: assert property ($rose(extOutEnable_n) |-> $past(extSelect_n) != 6'h3F && extSelect_n == 6'h3F)
    else $error("select not after strobe");
  a_start_together: assert property (take |=> extAddr == $past(reqAddr) && !extSelect_n[$past(reqSelect)])
    else $error("address and select apart");
  a_strobe_point: assert property (take |=> extOutEnable_n == $past(readStrobeAssertCtrl) ##1 !extOutEnable_n)
    else $error("strobe point wrong");
  a_be_suppress: assert property (!extOutEnable_n && byteEnableReadCtrl |-> byteEnable_n == 4'hF)
    else $error("byte enable in read");
  a_gap_idle: assert property ($rose(&extSelect_n) |=> &extSelect_n)
    else $error("no idle gap");
  a_timeout_err: assert property (rspBusErr |-> selCnt_ff >= 11'h3FC && selCnt_ff <= 11'h402)
    else $error("bus error at wrong count");
  a_select_bounded: assert property (selCnt_ff <= 11'h406)
    else $error("select never ends");
  a_internal_end: assert property (take && !(reqSelect == 3'h5 && ackMode) |-> ##[3:68] rspDone)
    else $error("internal wait hangs");
endmodule
bind ebatc_core ebatc_checker u_chk (.sys_clk(sys_clk), .reset_n(reset_n), .reqValid(reqValid),
  .reqAddr(reqAddr), .reqSelect(reqSelect), .reqReady(reqReady), .rspDone(rspDone), .rspBusErr(rspBusErr),
  .waitStateCount(waitStateCount), .ackWaitSelect(ackWaitSelect), .readStrobeAssertCtrl(readStrobeAssertCtrl),
  .byteEnableReadCtrl(byteEnableReadCtrl), .extAddr(extAddr), .extSelect_n(extSelect_n),
  .extOutEnable_n(extOutEnable_n), .byteEnable_n(byteEnable_n), .dataAck_n(dataAck_n));

// ### verification/ebatc_partner.sv
// far-side peripheral answering reads with an active-low acknowledge
`timescale 1ns/1ps
module ebatc_partner (
  // clock and pins
  input  wire        sys_clk,
  input  wire [5:0]  extSelect_n,
  input  wire [23:0] extAddr,
  // behaviour
  input  wire        ackOn,
  input  wire [31:0] ackDelay,
  // answer
  output reg         dataAck_n = 1'b1,
  output reg  [15:0] extDataIn = 16'h0000
);
  reg [31:0] waitCnt_ff = 32'h0000_0000;
  always @(posedge sys_clk) begin
    if (&extSelect_n) begin
      waitCnt_ff <= 32'h0000_0000;
      dataAck_n  <= 1'b1;
      extDataIn  <= ~extDataIn;
    end else begin
      waitCnt_ff <= waitCnt_ff + 32'h0000_0001;
      if (waitCnt_ff < ackDelay) extDataIn <= ~extDataIn;
      if (ackOn && waitCnt_ff == ackDelay) begin
        dataAck_n <= 1'b0;
        extDataIn <= extAddr[15:0] ^ 16'h5A5A;
      end
      if (waitCnt_ff == ackDelay + 32'h0000_0003) dataAck_n <= 1'b1;
    end
  end
endmodule

// ### verification/ebatc_tb.sv
// self-checking bench for the read engine
`timescale 1ns/1ps
module testbench;
  reg         sys_clk = 1'b0, reset_n = 1'b0, reqValid = 1'b0, ackOn = 1'b1;
  reg         ackWaitSelect = 1'b0, readStrobeAssertCtrl = 1'b0, byteEnableReadCtrl = 1'b0;
  reg  [23:0] reqAddr = 24'h00_0000;
  reg  [2:0]  reqSelect = 3'h0;
  reg  [3:0]  reqByteEn = 4'h0, beSeen;
  reg  [5:0]  waitStateCount = 6'h3F, selSeen;
  integer     ackDelay = 2, mismatches = 0, n_tests = 0, k;
  wire        reqReady, rspDone, rspBusErr, extReadWrite, extOutEnable_n, dataAck_n;
  wire [15:0] rspData, extDataIn;
  wire [23:0] extAddr;
  wire [5:0]  extSelect_n;
  wire [3:0]  byteEnable_n;
  ebatc_core DUT (.sys_clk(sys_clk), .reset_n(reset_n), .reqValid(reqValid), .reqAddr(reqAddr),
    .reqSelect(reqSelect), .reqByteEn(reqByteEn), .reqReady(reqReady), .rspDone(rspDone), .rspData(rspData),
    .rspBusErr(rspBusErr), .waitStateCount(waitStateCount), .ackWaitSelect(ackWaitSelect),
    .readStrobeAssertCtrl(readStrobeAssertCtrl), .byteEnableReadCtrl(byteEnableReadCtrl), .extAddr(extAddr),
    .extSelect_n(extSelect_n), .extReadWrite(extReadWrite), .extOutEnable_n(extOutEnable_n),
    .byteEnable_n(byteEnable_n), .dataAck_n(dataAck_n), .extDataIn(extDataIn));
  ebatc_partner u_far (.sys_clk(sys_clk), .extSelect_n(extSelect_n), .extAddr(extAddr), .ackOn(ackOn),
    .ackDelay(ackDelay), .dataAck_n(dataAck_n), .extDataIn(extDataIn));
  initial forever #4 sys_clk = ~sys_clk;
  task check(input [15:0] seen, input [15:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
    end
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // cfg holds ack select, strobe delay, byte enable suppress, partner ack on
  task readOp(input [2:0] sel, input [5:0] wait_state_count, input [3:0] cfg, input integer dly, input integer kind);
    begin
      for (k = 0; k < 40 && reqReady !== 1'b1; k = k + 1) @(negedge sys_clk);
      check(reqReady, 1'b1);
      @(posedge sys_clk);
      {ackWaitSelect, readStrobeAssertCtrl, byteEnableReadCtrl, ackOn} <= cfg;
      waitStateCount <= wait_state_count;
      ackDelay <= dly;
      reqSelect <= sel;
      reqAddr <= reqAddr + 24'h01_0203;
      reqByteEn <= reqByteEn + 4'h5;
      reqValid <= 1'b1;
      selSeen = 6'h3F;
      beSeen = 4'hF;
      @(posedge sys_clk) reqValid <= 1'b0;
      #1 check(extSelect_n, 6'h3F);
      for (k = 0; k < 1100 && rspDone !== 1'b1; k = k + 1) begin
        @(negedge sys_clk);
        if (extSelect_n != 6'h3F) selSeen = extSelect_n;
        if (!extOutEnable_n) beSeen = byteEnable_n;
      end
      check(rspDone, 1'b1);
      check(rspBusErr, kind == 2);
      check({extReadWrite, extOutEnable_n, byteEnable_n}, 6'h3F);
      check(selSeen, {10'h000, ~(6'h01 << sel)});
      if (kind == 0) check(rspData, reqAddr[15:0] ^ 16'h5A5A);
      if (kind == 1) check(k >= wait_state_count, 1'b1);
      if (sel == 3'h5) check(beSeen, {12'h000, cfg[1] ? 4'hF : ~reqByteEn});
    end
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    readOp(3'h5, 6'h3F, 4'b0001, 2, 0);
    readOp(3'h5, 6'h3F, 4'b0101, 0, 0);
    readOp(3'h5, 6'h3F, 4'b0011, 1016, 0);
    readOp(3'h3, 6'h3F, 4'b0001, 1, 1);
    readOp(3'h5, 6'h20, 4'b1001, 1, 1);
    readOp(3'h5, 6'h3F, 4'b0000, 0, 2);
    readOp(3'h5, 6'h3F, 4'b0001, 3, 0);
    conclude;
  end
  // watchdog well past the expected run
  initial begin
    #60000;
    mismatches = mismatches + 1;
    conclude;
  end
endmodule
